/* src/cid_pkg.sv */
// Package of constants for the caller-identity receiver configuration block
package cid_pkg;
  // Internal setting register addresses on the three-bit index
  localparam logic [2:0] ADDR_ROW_TOL = 3'h0;
  localparam logic [2:0] ADDR_COL_MODE = 3'h1;
  localparam logic [2:0] ADDR_ALERT_DATA_GAIN = 3'h2;
  localparam logic [2:0] ADDR_DIGIT_GAIN = 3'h3;
  localparam logic [2:0] ADDR_ALERT_DIGIT_HYST = 3'h4;
  localparam logic [2:0] ADDR_DATA_CARRIER_HYST = 3'h5;
  // Bit position of the load strobe inside the index register
  localparam int IDX_STROBE_BIT = 4;
  // Field positions in the column and mode register
  localparam int MODE_TONE_BIT = 4;
  localparam int PT_RESTART_BIT = 5;
  localparam int AT_PAUSE_BIT = 6;
  // Reset values
  localparam logic [7:0] ROW_TOL_RST = 8'h00;
  localparam logic [7:0] COL_MODE_RST = 8'h00;
  localparam logic [7:0] GAIN_RST = 8'h55;
  localparam logic [7:0] HYST_RST = 8'h00;
  localparam logic [7:0] GUARD_ZERO = 8'h00;
  // Gain nibble range
  localparam logic [3:0] GAIN_MAX = 4'ha;
  localparam logic [3:0] GAIN_UNITY = 4'h5;
  // Tolerance codes as decoded selections
  localparam logic [1:0] TOL_FINE = 2'h0;
  localparam logic [1:0] TOL_MID = 2'h1;
  localparam logic [1:0] TOL_WIDE = 2'h2;
  localparam logic [1:0] TOL_RSVD = 2'h3;
  // Guard timer tick: period in ns, cycles of the 50 ns system clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int GUARD_TICK_NS = 858000;
  localparam int GUARD_TICK_CYC = GUARD_TICK_NS / CLK_PERIOD_NS;
endpackage

/* src/cid_config.sv */
// Caller-identity receiver setting registers and digit guard timing
`timescale 1ns/1ns
module cid_config #(
  parameter int TICK_CYC = cid_pkg::GUARD_TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_gain_write_data,
  input wire logic [7:0] i_gain_write_index,
  input wire logic i_caller_global_enable,
  input wire logic i_data_decoder_enable,
  input wire logic [7:0] i_present_guard_limit,
  input wire logic [7:0] i_absent_guard_limit,
  input wire logic i_tone_seen,
  input wire logic [3:0] i_tone_digit,
  input wire logic i_data_ready,
  output logic [7:0] o_row_tolerance_reg,
  output logic [7:0] o_column_mode_reg,
  output logic [7:0] o_alert_data_gain_reg,
  output logic [7:0] o_digit_gain_reg,
  output logic [7:0] o_alert_digit_hysteresis_reg,
  output logic [7:0] o_data_carrier_hysteresis_reg,
  output logic [1:0] o_row_tol_sel,
  output logic [1:0] o_col_tol_sel,
  output logic o_tone_detect_mode,
  output logic [7:0] o_tone_result_reg,
  output logic o_digit_valid,
  output logic o_data_decoder_on
);
  // Tolerance nibble decode, shared by row and column
  function automatic logic [1:0] tol_decode(input logic [3:0] code);
    if (code[3:2] != 2'h0) begin
      tol_decode = cid_pkg::TOL_RSVD;
    end else if (code[1]) begin
      tol_decode = cid_pkg::TOL_WIDE;
    end else if (code[0]) begin
      tol_decode = cid_pkg::TOL_MID;
    end else begin
      tol_decode = cid_pkg::TOL_FINE;
    end
  endfunction

  // Gain nibble clamp: out-of-range codes would select no step
  function automatic logic [7:0] gain_fix(input logic [7:0] v);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = (v[7:4] > cid_pkg::GAIN_MAX) ? cid_pkg::GAIN_MAX : v[7:4];
    lo = (v[3:0] > cid_pkg::GAIN_MAX) ? cid_pkg::GAIN_MAX : v[3:0];
    gain_fix = {hi, lo};
  endfunction

  // Two-flop synchronisers for the analogue-side tone inputs
  logic tone_s1;
  logic tone_s2;
  logic [3:0] digit_s1;
  logic [3:0] digit_s2;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tone_s1 <= 1'b0;
      tone_s2 <= 1'b0;
      digit_s1 <= 4'h0;
      digit_s2 <= 4'h0;
    end else begin
      tone_s1 <= i_tone_seen;
      tone_s2 <= tone_s1;
      digit_s1 <= i_tone_digit;
      digit_s2 <= digit_s1;
    end
  end

  // Strobe edge detect on the index register
  logic strobe_d;
  logic load;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= i_gain_write_index[cid_pkg::IDX_STROBE_BIT];
    end
  end
  assign load = i_gain_write_index[cid_pkg::IDX_STROBE_BIT] & ~strobe_d;

  // Internal setting registers; upper row bits forced zero as reserved
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_row_tolerance_reg <= cid_pkg::ROW_TOL_RST;
      o_column_mode_reg <= cid_pkg::COL_MODE_RST;
      o_alert_data_gain_reg <= cid_pkg::GAIN_RST;
      o_digit_gain_reg <= cid_pkg::GAIN_RST;
      o_alert_digit_hysteresis_reg <= cid_pkg::HYST_RST;
      o_data_carrier_hysteresis_reg <= cid_pkg::HYST_RST;
    end else if (load) begin
      unique case (i_gain_write_index[2:0])
        cid_pkg::ADDR_ROW_TOL: o_row_tolerance_reg <= {4'h0, i_gain_write_data[3:0]};
        cid_pkg::ADDR_COL_MODE: o_column_mode_reg <= {1'b0, i_gain_write_data[6:0]};
        cid_pkg::ADDR_ALERT_DATA_GAIN: o_alert_data_gain_reg <= gain_fix(i_gain_write_data);
        cid_pkg::ADDR_DIGIT_GAIN: o_digit_gain_reg <= gain_fix(i_gain_write_data);
        cid_pkg::ADDR_ALERT_DIGIT_HYST: o_alert_digit_hysteresis_reg <= i_gain_write_data;
        cid_pkg::ADDR_DATA_CARRIER_HYST: o_data_carrier_hysteresis_reg <= i_gain_write_data;
        default: ;
      endcase
    end
  end

  // Decoded settings for the analogue side
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_row_tol_sel <= cid_pkg::TOL_FINE;
      o_col_tol_sel <= cid_pkg::TOL_FINE;
      o_tone_detect_mode <= 1'b0;
      o_data_decoder_on <= 1'b0;
    end else begin
      o_row_tol_sel <= tol_decode(o_row_tolerance_reg[3:0]);
      o_col_tol_sel <= tol_decode(o_column_mode_reg[3:0]);
      o_tone_detect_mode <= o_column_mode_reg[cid_pkg::MODE_TONE_BIT];
      o_data_decoder_on <= i_caller_global_enable & i_data_decoder_enable;
    end
  end

  // Guard timer tick prescaler
  logic [$clog2(TICK_CYC+1)-1:0] pre;
  logic tick;
  assign tick = (pre == '0);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre <= '0;
    end else if (tick) begin
      pre <= ($clog2(TICK_CYC+1))'(TICK_CYC - 1);
    end else begin
      pre <= pre - 1'b1;
    end
  end

  // Guard state machine: present count then absent count
  typedef enum logic [1:0] {CID_IDLE, CID_PRESENT, CID_VALID, CID_ABSENT} cid_state_e;
  cid_state_e state;
  logic [7:0] pt_cnt;
  logic [7:0] at_cnt;
  logic [3:0] last_digit;
  logic tone_ok;
  // Tone detector mode never validates digits
  assign tone_ok = tone_s2 & ~o_column_mode_reg[cid_pkg::MODE_TONE_BIT] & i_caller_global_enable;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= CID_IDLE;
      pt_cnt <= cid_pkg::GUARD_ZERO;
      at_cnt <= cid_pkg::GUARD_ZERO;
      last_digit <= 4'h0;
    end else begin
      unique case (state)
        CID_IDLE: begin
          pt_cnt <= cid_pkg::GUARD_ZERO;
          last_digit <= digit_s2;
          if (tone_ok) begin
            state <= CID_PRESENT;
          end
        end
        CID_PRESENT: begin
          last_digit <= digit_s2;
          if (!tone_ok) begin
            state <= CID_IDLE;
          end else if (o_column_mode_reg[cid_pkg::PT_RESTART_BIT] && digit_s2 != last_digit) begin
            pt_cnt <= cid_pkg::GUARD_ZERO;
          end else if (pt_cnt == i_present_guard_limit) begin
            state <= CID_VALID;
          end else if (tick) begin
            pt_cnt <= pt_cnt + 8'h01;
          end
        end
        CID_VALID: begin
          at_cnt <= cid_pkg::GUARD_ZERO;
          if (!tone_ok) begin
            state <= CID_ABSENT;
          end
        end
        CID_ABSENT: begin
          if (at_cnt == i_absent_guard_limit) begin
            state <= CID_IDLE;
            pt_cnt <= cid_pkg::GUARD_ZERO;
          end else if (tick) begin
            if (!tone_ok) begin
              at_cnt <= at_cnt + 8'h01;
            end else if (!o_column_mode_reg[cid_pkg::AT_PAUSE_BIT]) begin
              if (at_cnt == cid_pkg::GUARD_ZERO) begin
                state <= CID_VALID;
              end else begin
                at_cnt <= at_cnt - 8'h01;
              end
            end
          end
        end
      endcase
    end
  end

  // Result register and valid flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tone_result_reg <= 8'h00;
      o_digit_valid <= 1'b0;
    end else begin
      if (state == CID_PRESENT && tone_ok && pt_cnt == i_present_guard_limit
          && !(o_column_mode_reg[cid_pkg::PT_RESTART_BIT] && digit_s2 != last_digit)) begin
        o_tone_result_reg <= {4'h0, digit_s2};
        o_digit_valid <= 1'b1;
      end else if (state == CID_ABSENT && at_cnt == i_absent_guard_limit) begin
        o_digit_valid <= 1'b0;
      end
    end
  end

  // Assertions
  a_load_row_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    load && i_gain_write_index[2:0] == cid_pkg::ADDR_ROW_TOL |=> o_row_tolerance_reg[7:4] == 4'h0)
    else $error("row reserved bits not zero");
  a_row_tol_map: assert property (@(posedge i_clk) disable iff (i_rst)
    o_row_tolerance_reg[3:0] == 4'h1 |=> o_row_tol_sel == cid_pkg::TOL_MID)
    else $error("row tolerance decode wrong");
  a_col_tol_map: assert property (@(posedge i_clk) disable iff (i_rst)
    o_column_mode_reg[3:1] == 3'h1 |=> o_col_tol_sel == cid_pkg::TOL_WIDE)
    else $error("column tolerance decode wrong");
  a_mode_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_tone_detect_mode == $past(o_column_mode_reg[cid_pkg::MODE_TONE_BIT]))
    else $error("mode bit not followed");
  a_pt_restart: assert property (@(posedge i_clk) disable iff (i_rst)
    state == CID_PRESENT && tone_ok && o_column_mode_reg[cid_pkg::PT_RESTART_BIT]
    && digit_s2 != last_digit |=> pt_cnt == 8'h00)
    else $error("present counter not restarted");
  a_at_pause: assert property (@(posedge i_clk) disable iff (i_rst)
    state == CID_ABSENT && tone_ok && o_column_mode_reg[cid_pkg::AT_PAUSE_BIT]
    |=> $stable(at_cnt))
    else $error("absent counter did not pause");
  a_gain_range: assert property (@(posedge i_clk) disable iff (i_rst)
    o_digit_gain_reg[3:0] <= cid_pkg::GAIN_MAX && o_alert_data_gain_reg[7:4] <= cid_pkg::GAIN_MAX)
    else $error("gain nibble out of range");
  a_hyst_load: assert property (@(posedge i_clk) disable iff (i_rst)
    load && i_gain_write_index[2:0] == cid_pkg::ADDR_ALERT_DIGIT_HYST
    |=> o_alert_digit_hysteresis_reg == $past(i_gain_write_data))
    else $error("hysteresis not loaded");
  a_decoder_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_data_decoder_enable |=> !o_data_decoder_on)
    else $error("data decoder not disabled");
  a_no_load_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !load |=> $stable(o_column_mode_reg))
    else $error("setting changed without strobe edge");
  a_valid_digit: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_digit_valid) |-> o_tone_result_reg[3:0] == $past(digit_s2) && pt_cnt == i_present_guard_limit)
    else $error("digit not captured at validation");
  a_absent_drop: assert property (@(posedge i_clk) disable iff (i_rst)
    state == CID_ABSENT && at_cnt == i_absent_guard_limit |=> !o_digit_valid && state == CID_IDLE)
    else $error("valid not dropped at absent limit");
  c_load_col: cover property (@(posedge i_clk) load && i_gain_write_index[2:0] == cid_pkg::ADDR_COL_MODE);
  c_digit_ok: cover property (@(posedge i_clk) $rose(o_digit_valid));
  c_digit_end: cover property (@(posedge i_clk) $fell(o_digit_valid));
  c_absent_pause: cover property (@(posedge i_clk) state == CID_ABSENT && tone_ok
    && o_column_mode_reg[cid_pkg::AT_PAUSE_BIT]);
endmodule

/* test/cid_config_tb.sv */
// Self-checking bench for the caller-identity setting registers and digit guard timing
`timescale 1ns/1ns
module cid_config_tb;
  // Short tick keeps guard runs brief
  localparam int TICK = 4;
  logic i_clk, i_rst, i_caller_global_enable, i_data_decoder_enable, i_tone_seen, i_data_ready;
  logic [7:0] i_gain_write_data, i_gain_write_index, i_present_guard_limit, i_absent_guard_limit;
  logic [3:0] i_tone_digit;
  logic [7:0] o_row_tolerance_reg, o_column_mode_reg, o_alert_data_gain_reg, o_digit_gain_reg;
  logic [7:0] o_alert_digit_hysteresis_reg, o_data_carrier_hysteresis_reg, o_tone_result_reg;
  logic [1:0] o_row_tol_sel, o_col_tol_sel;
  logic o_tone_detect_mode, o_digit_valid, o_data_decoder_on;
  logic [7:0] model [0:5];
  int fails, checks_done, n;
  logic dropped;

  cid_config #(.TICK_CYC(TICK)) i_cid_config (.i_clk(i_clk), .i_rst(i_rst),
    .i_gain_write_data(i_gain_write_data), .i_gain_write_index(i_gain_write_index),
    .i_caller_global_enable(i_caller_global_enable),
    .i_data_decoder_enable(i_data_decoder_enable),
    .i_present_guard_limit(i_present_guard_limit), .i_absent_guard_limit(i_absent_guard_limit),
    .i_tone_seen(i_tone_seen), .i_tone_digit(i_tone_digit), .i_data_ready(i_data_ready),
    .o_row_tolerance_reg(o_row_tolerance_reg), .o_column_mode_reg(o_column_mode_reg),
    .o_alert_data_gain_reg(o_alert_data_gain_reg), .o_digit_gain_reg(o_digit_gain_reg),
    .o_alert_digit_hysteresis_reg(o_alert_digit_hysteresis_reg),
    .o_data_carrier_hysteresis_reg(o_data_carrier_hysteresis_reg),
    .o_row_tol_sel(o_row_tol_sel), .o_col_tol_sel(o_col_tol_sel),
    .o_tone_detect_mode(o_tone_detect_mode), .o_tone_result_reg(o_tone_result_reg),
    .o_digit_valid(o_digit_valid), .o_data_decoder_on(o_data_decoder_on));

  // Expected register contents: reserved bits zero, gain nibbles clamped at ten
  function automatic logic [7:0] exp_reg(input logic [2:0] a, input logic [7:0] d);
    case (a)
      3'h0: return {4'h0, d[3:0]};
      3'h1: return {1'b0, d[6:0]};
      3'h2, 3'h3: return {(d[7:4] > 4'ha) ? 4'ha : d[7:4], (d[3:0] > 4'ha) ? 4'ha : d[3:0]};
      default: return d;
    endcase
  endfunction

  // Tolerance code to selection, reserved codes map to the reserved selection
  function automatic logic [1:0] exp_sel(input logic [3:0] c);
    if (c == 4'h0) return 2'h0;
    if (c == 4'h1) return 2'h1;
    if (c[3:1] == 3'h1) return 2'h2;
    return 2'h3;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // All six targets compared, so a stray write to another target shows too
  task automatic check_regs();
    chk("row_tolerance_reg", model[0], o_row_tolerance_reg);
    chk("column_mode_reg", model[1], o_column_mode_reg);
    chk("alert_data_gain_reg", model[2], o_alert_data_gain_reg);
    chk("digit_gain_reg", model[3], o_digit_gain_reg);
    chk("alert_digit_hysteresis_reg", model[4], o_alert_digit_hysteresis_reg);
    chk("data_carrier_hysteresis_reg", model[5], o_data_carrier_hysteresis_reg);
    chk("row_tol_sel", {6'h0, exp_sel(model[0][3:0])}, {6'h0, o_row_tol_sel});
    chk("col_tol_sel", {6'h0, exp_sel(model[1][3:0])}, {6'h0, o_col_tol_sel});
    chk("tone_detect_mode", {7'h0, model[1][4]}, {7'h0, o_tone_detect_mode});
  endtask

  // Strobe low, then high for one cycle, then settle past the selection lag
  task automatic load(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_gain_write_data <= d;
    i_gain_write_index <= {5'h00, a};
    @(posedge i_clk);
    i_gain_write_index[4] <= 1'b1;
    @(posedge i_clk);
    i_gain_write_index[4] <= 1'b0;
    if (a < 3'h6) model[a] = exp_reg(a, d);
    repeat (3) @(posedge i_clk);
    #1;
    check_regs();
  endtask

  // Bounded wait for the valid level; running out ends the run
  task automatic wait_valid(input logic lvl, input int bound, output int cyc);
    cyc = 0;
    while (o_digit_valid !== lvl && cyc < bound) begin
      @(posedge i_clk);
      #1;
      cyc++;
    end
    if (cyc >= bound) begin
      fails++;
      $display("CHECK FAILED digit_valid expected %b seen %b", lvl, o_digit_valid);
      give_verdict();
    end
  endtask

  // Three six-cycle gaps in a held tone; notes whether valid was ever seen low
  task automatic tone_gaps(output logic fell);
    fell = 1'b0;
    for (int c = 0; c < 90; c++) begin
      @(posedge i_clk);
      i_tone_seen <= (c % 30) >= 6;
      #1;
      if (o_digit_valid !== 1'b1) fell = 1'b1;
    end
  endtask

  // Free-running clock, 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Main sequence
  initial begin
    i_rst = 1'b1;
    {i_caller_global_enable, i_data_decoder_enable, i_tone_seen, i_data_ready} = 4'h0;
    {i_gain_write_data, i_gain_write_index, i_tone_digit} = 20'h0_0000;
    i_present_guard_limit = 8'h03;
    i_absent_guard_limit = 8'h02;
    model = '{8'h00, 8'h00, 8'h55, 8'h55, 8'h00, 8'h00};
    fails = 0;
    checks_done = 0;
    void'($urandom(16));
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    check_regs();
    chk("digit_valid", 8'h00, {7'h0, o_digit_valid});
    // Every tolerance code for both tone groups, junk in the reserved bits
    for (int c = 0; c < 16; c++) begin
      load(3'h0, {$urandom_range(15), c[3:0]});
      load(3'h1, {$urandom_range(15), c[3:0]});
    end
    load(3'h2, 8'hab);
    load(3'h3, 8'hf5);
    for (int k = 0; k < 40; k++) load($urandom_range(7), $urandom_range(255));
    // Decoder enable needs both enables
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      i_caller_global_enable <= k[1];
      i_data_decoder_enable <= k[0];
      repeat (2) @(posedge i_clk);
      #1;
      chk("data_decoder_on", {7'h0, k[1] & k[0]}, {7'h0, o_data_decoder_on});
    end
    // Dropping the data enable alone must switch the decoder off
    @(posedge i_clk);
    i_data_decoder_enable <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("data_decoder_off", 8'h00, {7'h0, o_data_decoder_on});
    // Enable held high for the rest of the run, decoded data simply ignored
    @(posedge i_clk);
    i_data_decoder_enable <= 1'b1;
    // Present then absent guard, digit decoder mode
    load(3'h1, 8'h00);
    @(posedge i_clk);
    i_tone_digit <= 4'h9;
    i_tone_seen <= 1'b1;
    wait_valid(1'b1, 100, n);
    chk("present_time_in_range", 8'h01, {7'h0, n >= 2 * TICK && n <= 4 * TICK + 6});
    chk("tone_result_reg", 8'h09, o_tone_result_reg);
    @(posedge i_clk);
    i_tone_seen <= 1'b0;
    wait_valid(1'b0, 100, n);
    chk("absent_time_in_range", 8'h01, {7'h0, n >= TICK && n <= 3 * TICK + 6});
    // Tone presence mode blocks digit validation
    load(3'h1, 8'h10);
    @(posedge i_clk);
    i_tone_seen <= 1'b1;
    repeat (40) @(posedge i_clk);
    #1;
    chk("digit_valid_tone_mode", 8'h00, {7'h0, o_digit_valid});
    // Restart on digit change: a digit flipping every three cycles never validates
    load(3'h1, 8'h20);
    for (int k = 0; k < 20; k++) begin
      repeat (3) @(posedge i_clk);
      i_tone_digit <= i_tone_digit ^ 4'h5;
    end
    #1;
    chk("digit_valid_restart", 8'h00, {7'h0, o_digit_valid});
    wait_valid(1'b1, 100, n);
    chk("tone_result_stable", {4'h0, i_tone_digit}, o_tone_result_reg);
    @(posedge i_clk);
    i_tone_seen <= 1'b0;
    wait_valid(1'b0, 100, n);
    // Without restart, the same flipping digit still validates
    load(3'h1, 8'h00);
    @(posedge i_clk);
    i_tone_seen <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      repeat (3) @(posedge i_clk);
      i_tone_digit <= i_tone_digit ^ 4'h5;
    end
    #1;
    chk("digit_valid_no_restart", 8'h01, {7'h0, o_digit_valid});
    // Short gaps with up-down counting: the tone's return wins back every gap
    @(posedge i_clk);
    i_absent_guard_limit <= 8'h03;
    tone_gaps(dropped);
    chk("valid_dropped_up_down", 8'h00, {7'h0, dropped});
    // Same gaps with pausing: absences add up until the limit drops valid
    load(3'h1, 8'h40);
    tone_gaps(dropped);
    chk("valid_dropped_pause", 8'h01, {7'h0, dropped});
    // Caller flag lives outside this block, so the bench has none to clear
    give_verdict();
  end
endmodule
